//--- verilog/dchs_cfg.svh
`ifndef DCHS_CFG_SVH
`define DCHS_CFG_SVH
// Register indices on the three-bit select
`define DCHS_IDX_DATA    3'h0
`define DCHS_IDX_MSR     3'h6
`define DCHS_IDX_AFR     3'h2
`define DCHS_IDX_EFR     3'h3
// Field positions
`define DCHS_AFR_BCAST   0
`define DCHS_EFR_AUTOCTS 7
`define DCHS_MSR_CTS     4
`define DCHS_MSR_CD      7
// Reset values and data bus width
`define DCHS_REG_RST     8'h00
`define DCHS_SYNC_RST    8'hfe
`define DCHS_BUS_W       8
`endif

//--- verilog/dchs_pkg.sv
package dchs_pkg;
  typedef logic [7:0] dchs_byte_t;
  typedef enum logic [0:0] { DCHS_CH_B, DCHS_CH_A } dchs_ch_e;
endpackage

//--- verilog/dchs_chan_if.sv
interface dchs_chan_if;
  logic       wr_en;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       auto_cts;
  logic       bcast;
  modport host (output wr_en, output addr, output wdata,
                input rdata, input auto_cts, input bcast);
  modport chan (input wr_en, input addr, input wdata,
                output rdata, output auto_cts, output bcast);
endinterface

//--- verilog/dchs_channel.sv
`include "dchs_cfg.svh"
module dchs_channel
  import dchs_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_cd_n_q,
  input  wire logic i_cts_n_q,
  dchs_chan_if.chan bus
);
  dchs_byte_t regs_r [8];
  dchs_byte_t regs_nxt [8];
  dchs_byte_t modem_status_reg;

  // Next register contents on a write
  always_comb begin
    regs_nxt = regs_r;
    if (bus.wr_en) begin
      regs_nxt[bus.addr] = bus.wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 8; i++) regs_r[i] <= `DCHS_REG_RST;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // Modem status bits 7 and 4 reflect pins, low means asserted; other bits keep the written value
  always_comb begin
    modem_status_reg = regs_r[`DCHS_IDX_MSR] & 8'h6f & 8'h7f;
    // RQ7: carrier mirror
    modem_status_reg[`DCHS_MSR_CD]  = ~i_cd_n_q;
    // RQ9: cts status bit
    modem_status_reg[`DCHS_MSR_CTS] = ~i_cts_n_q;
  end

  assign bus.rdata    = (bus.addr == `DCHS_IDX_MSR) ? modem_status_reg : regs_r[bus.addr];
  assign bus.auto_cts = regs_r[`DCHS_IDX_EFR][`DCHS_EFR_AUTOCTS];
  assign bus.bcast    = regs_r[`DCHS_IDX_AFR][`DCHS_AFR_BCAST];
endmodule // dchs_channel

//--- verilog/dchs_host_port.sv
`include "dchs_cfg.svh"
// Overview of operation
// RQ1: With chip select low, channel pick 1 selects channel A and 0 selects B.
// RQ2: Active-low chip select enables transfers to the picked channel.
// RQ3: Broadcast bit 0 of the alternate function reg makes a write hit both.
// RQ4: Three select inputs address the register inside the channel.
// RQ5: The 8-bit data bus is driven only while read data is returned.
// RQ6: Data bus bit 0 is the first serial bit on the line.
// RQ7: Low carrier detect means carrier present, mirrored in modem status.
// RQ8: Low clear-to-send means the remote end may accept transmit data.
// RQ9: Clear-to-send state reads at bit 4 of modem status.
// RQ10: Clear-to-send gates transmit only when enhanced feature bit 7 is set.
// RQ11: A falling read strobe puts the addressed register on the bus.
// RQ12: A rising write strobe captures the bus into the addressed register.
// RQ13: With chip select high both strobes are ignored and the bus floats.
// RQ14: The host keeps address, select and pick steady through each strobe.
module dchs_host_port
  import dchs_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_chip_sel_n,
  input  wire logic       i_channel_pick,
  input  wire logic [2:0] i_reg_select,
  input  wire logic       i_read_strobe_n,
  input  wire logic       i_write_strobe_n,
  input  wire logic [7:0] i_host_data_bus,
  output logic      [7:0] o_host_data_bus,
  output logic            o_host_data_oe_n,
  input  wire logic       i_carrier_detect_n_a,
  input  wire logic       i_carrier_detect_n_b,
  input  wire logic       i_cts_n_a,
  input  wire logic       i_cts_n_b,
  output logic            o_tx_allow_a,
  output logic            o_tx_allow_b,
  output logic            o_bcast_mode
);
  // Three-stage synchronisers for the eight control and status pins; stage 2 and 3 must agree
  // A level caught mid-transition in stage 1 never reaches the decode,
  // at the price of about four clocks of latency per pin
  logic [7:0] s1_r;     // First stage, metastability catcher
  logic [7:0] s2_r;
  logic [7:0] s3_r;
  logic [7:0] f_r;      // Agreed level seen by the decode
  logic [7:0] s1_nxt;
  logic [7:0] s2_nxt;
  logic [7:0] s3_nxt;
  logic [7:0] f_nxt;
  logic [7:0] raw;
  // Pin bundle; bit order fixes the taps below
  assign raw = {i_carrier_detect_n_b, i_carrier_detect_n_a, i_cts_n_b,
                i_cts_n_a, i_chip_sel_n, i_read_strobe_n, i_write_strobe_n,
                i_channel_pick};

  always_comb begin
    s1_nxt = raw;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    f_nxt  = f_r;
    // Hold the old level while the last two stages disagree
    for (int i = 0; i < 8; i++) begin
      if (s2_r[i] == s3_r[i]) f_nxt[i] = s3_r[i];
    end
  end

  // Strobes and selects idle high; filtered values start idle
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_r <= `DCHS_SYNC_RST;
      s2_r <= `DCHS_SYNC_RST;
      s3_r <= `DCHS_SYNC_RST;
      f_r  <= `DCHS_SYNC_RST;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      f_r  <= f_nxt;
    end
  end

  // Agreed pin levels
  logic pick_q;
  logic wr_n_q;
  logic rd_n_q;
  logic cs_n_q;
  logic cts_n_a_q;
  logic cts_n_b_q;
  logic cd_n_a_q;
  logic cd_n_b_q;
  assign pick_q    = f_r[0];
  assign wr_n_q    = f_r[1];
  assign rd_n_q    = f_r[2];
  assign cs_n_q    = f_r[3];
  assign cts_n_a_q = f_r[4];
  assign cts_n_b_q = f_r[5];
  assign cd_n_a_q  = f_r[6];
  assign cd_n_b_q  = f_r[7];

  // Previous strobe levels for edge detection
  // Reset high like the idle pins, so release makes no false edge
  logic wr_prev_r;
  logic rd_prev_r;
  logic wr_prev_nxt;
  logic rd_prev_nxt;
  logic wr_rise;
  logic rd_fall;
  // RQ12: write on release
  assign wr_rise = wr_n_q & ~wr_prev_r;
  // RQ11: read on fall
  assign rd_fall = ~rd_n_q & rd_prev_r;

  // Data taken unregistered from the bus; stable per host hold contract
  // Taken raw: the host holds them past the strobe, so the filter
  // delay on the strobe cannot race them
  logic [2:0] addr_q;
  logic [7:0] wdata_q;
  // RQ14: host holds address
  assign addr_q  = i_reg_select;
  assign wdata_q = i_host_data_bus;

  // One carrier per channel; broadcast raises both write enables
  dchs_chan_if ch_a ();
  dchs_chan_if ch_b ();
  // Either channel's bit enables it, so one broadcast write can clear it
  logic bcast;
  // RQ3: broadcast override
  assign bcast = ch_a.bcast | ch_b.bcast;

  // Channel write routing
  always_comb begin
    ch_a.addr  = addr_q;
    ch_b.addr  = addr_q;
    ch_a.wdata = wdata_q;
    ch_b.wdata = wdata_q;
    // RQ13: deselected ignores strobes
    // RQ1: pick chooses channel
    ch_a.wr_en = wr_rise & ~cs_n_q & (bcast | pick_q);
    ch_b.wr_en = wr_rise & ~cs_n_q & (bcast | ~pick_q);
  end

  // RQ4: register addressing
  dchs_channel u_chan_a (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_cd_n_q  (cd_n_a_q),
    .i_cts_n_q (cts_n_a_q),
    .bus       (ch_a.chan)
  );

  dchs_channel u_chan_b (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_cd_n_q  (cd_n_b_q),
    .i_cts_n_q (cts_n_b_q),
    .bus       (ch_b.chan)
  );

  // Read data and bus drive
  // Held until the strobe or select is seen high again
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;
  logic       oe_n_r;
  logic       oe_n_nxt;
  logic       txa_r;
  logic       txa_nxt;
  logic       txb_r;
  logic       txb_nxt;
  logic       bc_r;
  logic       bc_nxt;

  always_comb begin
    wr_prev_nxt = wr_n_q;
    rd_prev_nxt = rd_n_q;
    dout_nxt    = dout_r;
    oe_n_nxt    = oe_n_r;
    // Read data is frozen at the strobe fall; later register changes
    // do not move the bus until the next read
    // RQ2: selected transfer
    if (rd_fall && !cs_n_q) begin
      // RQ6: bit 0 is first serial bit, kept unswapped
      dout_nxt = (pick_q == DCHS_CH_A) ? ch_a.rdata : ch_b.rdata;
      oe_n_nxt = 1'b0;
    end
    // RQ5: drive only during read
    if (rd_n_q || cs_n_q) begin
      oe_n_nxt = 1'b1;
    end
    // Without auto flow control the transmitter is never held
    // RQ8: low cts means ready
    // RQ10: auto flow gate
    txa_nxt = ~ch_a.auto_cts | ~cts_n_a_q;
    txb_nxt = ~ch_b.auto_cts | ~cts_n_b_q;
    bc_nxt  = bcast;
  end

  // Edge and output registers
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_prev_r <= 1'b1;
      rd_prev_r <= 1'b1;
      dout_r    <= `DCHS_REG_RST;
      oe_n_r    <= 1'b1;
      txa_r     <= 1'b1;
      txb_r     <= 1'b1;
      bc_r      <= 1'b0;
    end else begin
      wr_prev_r <= wr_prev_nxt;
      rd_prev_r <= rd_prev_nxt;
      dout_r    <= dout_nxt;
      oe_n_r    <= oe_n_nxt;
      txa_r     <= txa_nxt;
      txb_r     <= txb_nxt;
      bc_r      <= bc_nxt;
    end
  end

  assign o_host_data_bus  = dout_r;
  assign o_host_data_oe_n = oe_n_r;
  assign o_tx_allow_a     = txa_r;
  assign o_tx_allow_b     = txb_r;
  assign o_bcast_mode     = bc_r;
endmodule // dchs_host_port

//--- test/dchs_host_port_props.sv
module dchs_host_port_props (
  input wire logic       i_sys_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_chip_sel_n,
  input wire logic       i_read_strobe_n,
  input wire logic       i_write_strobe_n,
  input wire logic       i_cts_n_a,
  input wire logic       i_cts_n_b,
  input wire logic [7:0] o_host_data_bus,
  input wire logic       o_host_data_oe_n,
  input wire logic       o_tx_allow_a,
  input wire logic       o_tx_allow_b,
  input wire logic       o_bcast_mode
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // Eight idle cycles cover the synchroniser delay
  cs_float_a: assert property (i_chip_sel_n [*8] |-> o_host_data_oe_n)
    else $error("bus driven while deselected");
  rd_idle_a: assert property (i_read_strobe_n [*8] |-> o_host_data_oe_n)
    else $error("bus driven without read");
  rd_cause_a: assert property ($fell(o_host_data_oe_n)
    |-> !i_read_strobe_n && !i_chip_sel_n) else $error("drive without read");
  rd_hold_a: assert property (!o_host_data_oe_n && !$past(o_host_data_oe_n)
    |-> $stable(o_host_data_bus)) else $error("read data moved");
  cts_ok_a: assert property (!i_cts_n_a [*8] |-> o_tx_allow_a)
    else $error("channel a blocked with cts low");
  cts_okb_a: assert property (!i_cts_n_b [*8] |-> o_tx_allow_b)
    else $error("channel b blocked with cts low");
  auto_gate_a: assert property ($fell(o_tx_allow_a) |-> i_cts_n_a)
    else $error("transmit stopped with cts low");
  bcast_src_a: assert property ($rose(o_bcast_mode)
    |-> i_write_strobe_n && !i_chip_sel_n) else $error("bcast without write");
  cover property ($fell(o_host_data_oe_n));
  cover property ($rose(o_bcast_mode));
  cover property ($fell(o_tx_allow_a));
endmodule // dchs_host_port_props

bind dchs_host_port dchs_host_port_props u_props (.i_sys_clk, .i_sys_rst,
  .i_chip_sel_n, .i_read_strobe_n, .i_write_strobe_n, .i_cts_n_a,
  .i_cts_n_b, .o_host_data_bus, .o_host_data_oe_n, .o_tx_allow_a,
  .o_tx_allow_b, .o_bcast_mode);

//--- test/dchs_cpu_model.sv
module dchs_cpu_model (
  input  wire logic       i_clk,
  output logic            o_cs_n,
  output logic            o_pick,
  output logic [2:0]      o_sel,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic [7:0]      o_bus,
  input  wire logic [7:0] i_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus: deselected, strobes high
  initial begin
    {o_cs_n, o_pick, o_sel, o_rd_n, o_wr_n, o_bus} = {5'h11, 2'h3, 8'h00};
  end
  // One access; select settles before the strobe to beat the filter
  task automatic acc(input logic wr, cs_n, pick, input logic [2:0] sel,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk) #5;
    {o_cs_n, o_pick, o_sel} = {cs_n, pick, sel};
    o_bus = wr ? d : ~o_bus;
    repeat (4) @(posedge i_clk) #5;
    if (wr) o_wr_n = 1'b0; else o_rd_n = 1'b0;
    repeat (8) @(posedge i_clk) #5;
    q = i_bus;
    {o_rd_n, o_wr_n} = 2'h3;
    // select and data held past release
    repeat (8) @(posedge i_clk) #5;
    o_cs_n = 1'b1;
    o_bus = ~o_bus;
  endtask
endmodule // dchs_cpu_model

//--- test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_sys_rst, i_chip_sel_n, i_channel_pick, i_read_strobe_n;
  logic i_write_strobe_n, o_host_data_oe_n, o_tx_allow_a, o_tx_allow_b;
  logic i_carrier_detect_n_a, i_carrier_detect_n_b, i_cts_n_a, i_cts_n_b;
  logic o_bcast_mode;
  logic [2:0] i_reg_select;
  logic [7:0] i_host_data_bus, o_host_data_bus, cpu_bus, q;
  int error_cnt, n_tests;
  // Bus wire: device wins while it drives
  assign i_host_data_bus = o_host_data_oe_n ? cpu_bus : o_host_data_bus;
  dchs_host_port u_dchs_host_port (.i_sys_clk, .i_sys_rst, .i_chip_sel_n,
    .i_channel_pick, .i_reg_select, .i_read_strobe_n, .i_write_strobe_n,
    .i_host_data_bus, .o_host_data_bus, .o_host_data_oe_n,
    .i_carrier_detect_n_a, .i_carrier_detect_n_b, .i_cts_n_a, .i_cts_n_b,
    .o_tx_allow_a, .o_tx_allow_b, .o_bcast_mode);
  dchs_cpu_model u_dchs_cpu_model (.i_clk(i_sys_clk), .o_cs_n(i_chip_sel_n),
    .o_pick(i_channel_pick), .o_sel(i_reg_select), .o_rd_n(i_read_strobe_n),
    .o_wr_n(i_write_strobe_n), .o_bus(cpu_bus), .i_bus(i_host_data_bus));
  always #25 i_sys_clk = ~i_sys_clk;
  task automatic chk(input string nm, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic cs, p, input logic [2:0] a, input logic [7:0] d);
    u_dchs_cpu_model.acc(1'b1, cs, p, a, d, q);
  endtask
  task automatic rd(input logic p, input logic [2:0] a, input logic [7:0] m, e,
                    input string nm);
    u_dchs_cpu_model.acc(1'b0, 1'b0, p, a, 8'h00, q);
    chk(nm, q & m, e);
    chk("bus float", {7'h00, o_host_data_oe_n}, 8'h01);
  endtask
  // Watchdog well past the expected run
  initial begin
    #400000;
    error_cnt++;
    end_sim();
  end
  initial begin
    {i_sys_clk, i_sys_rst} = 2'h1;
    {i_carrier_detect_n_a, i_carrier_detect_n_b, i_cts_n_a, i_cts_n_b} = 4'h7;
    repeat (8) @(posedge i_sys_clk) #5;
    i_sys_rst = 1'b0;
    repeat (4) @(posedge i_sys_clk) #5;
    chk("reset out", {5'h00, o_tx_allow_a, o_tx_allow_b, o_bcast_mode}, 8'h06);
    wr(0, 1, 3'h0, 8'h5a);
    wr(0, 0, 3'h0, 8'ha5);
    wr(0, 0, 3'h3, 8'h7e);
    wr(1, 1, 3'h0, 8'h11);
    rd(1, 3'h0, 8'hff, 8'h5a, "reg a");
    rd(0, 3'h0, 8'hff, 8'ha5, "reg b");
    rd(0, 3'h3, 8'hff, 8'h7e, "reg b idx3");
    rd(1, 3'h6, 8'h90, 8'h80, "status a");
    rd(0, 3'h6, 8'h90, 8'h00, "status b");
    wr(0, 1, 3'h3, 8'h80);
    chk("gated", {6'h00, o_tx_allow_a, o_tx_allow_b}, 8'h01);
    i_cts_n_a = 1'b0;
    repeat (8) @(posedge i_sys_clk) #5;
    chk("cts low", {6'h00, o_tx_allow_a, o_tx_allow_b}, 8'h03);
    rd(1, 3'h6, 8'h90, 8'h90, "status cts");
    wr(0, 0, 3'h2, 8'h01);
    chk("bcast on", {7'h00, o_bcast_mode}, 8'h01);
    wr(0, 0, 3'h0, 8'h77);
    rd(1, 3'h0, 8'hff, 8'h77, "bcast a");
    wr(0, 1, 3'h2, 8'h00);
    chk("bcast off", {7'h00, o_bcast_mode}, 8'h00);
    end_sim();
  end
endmodule // tb
